// [dtc_defs.svh]
// Register indices, field positions, reset values and clock counts of the timer pair.
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ****************************************
// Register indices on the data-memory port
// ****************************************
`define DTC_IDX_COUNT8_VALUE     3'h0
`define DTC_IDX_COUNT16_LOW      3'h1
`define DTC_IDX_COUNT16_HIGH     3'h2
`define DTC_IDX_COUNT8_CONTROL   3'h3
`define DTC_IDX_COUNT16_CONTROL  3'h4
`define DTC_IDX_MISC             3'h5

// ****************************************
// Field positions and masks
// ****************************************
`define DTC_MISC_DIV_SEL_BIT     1
`define DTC_CTRL8_WRITE_MASK     8'hDF
`define DTC_CTRL16_WRITE_MASK    8'hF8

// ****************************************
// Reset values
// ****************************************
`define DTC_CTRL8_RESET          8'h00
`define DTC_CTRL16_RESET         8'h08
`define DTC_MISC_RESET           8'h00

// ****************************************
// Clock counts
// ****************************************
`define DTC_SYS_DIV4_LAST        2'h3
`define DTC_PRESCALE_WIDTH       7

`endif

// [dtc_pkg.sv]
// Types shared by the timer pair: mode codes and the control register layout.
package dtc_pkg;

  // Operating modes held in the top two control bits.
  typedef enum logic [1:0] {
    DTC_MODE_EXT_EVENT = 2'b00,
    DTC_MODE_INT_EVENT = 2'b01,
    DTC_MODE_TIMER     = 2'b10,
    DTC_MODE_PULSE     = 2'b11
  } dtc_mode_t;

  // Control register image, bit 7 down to bit 0.
  typedef struct packed {
    dtc_mode_t  mode_sel;
    logic       clock_sel;
    logic       run;
    logic       edge_sel;
    logic [2:0] prescale_sel;
  } dtc_ctrl_t;

endpackage

// [dtc_timer_pair.sv]
// Dual timer/event counter with data-memory register access.
//
// Functional notes
// - One 8-bit prescaled, one 16-bit up-counter.
// - Mode in control bits seven and six.
// - 10 timer, 11 pulse, 0x events.
// - Bit four run: set counts, clear holds.
// - Low three bits set 8-bit prescale ratio.
// - Prescaler ignored for event clock sources.
// - Timer and pulse modes use internal clock.
// - 16-bit clock: sub clock or sys/4.
// - Event mode: one count per pin edge.
// - Bit three selects active edge polarity.
// - Edge zero rising, edge one falling counted.
// - Internal event mode counts comparator transitions.
// - Counting past all ones overflows, requests interrupt.
// - Overflow reloads preload, counting continues.
// - Preload register has no reset value.
// - Stopped: preload write also loads count.
// - Running: preload write waits for overflow.
// - Value registers read live count; 16-bit low reads latch.
// - 16-bit low write only fills buffer.
// - High write loads high and buffered low.
// - High read latches low for later read.
// - Select bit picks divider source counter.
// - Pulse mode: stop, clear run at return.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

// ****************************************
// Input synchroniser with edge detection
// ****************************************
module dtc_sync_edge (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic raw_in,
  output var  logic rise_out,
  output var  logic fall_out
);
  logic meta;
  logic stable;
  logic prev;

  // Two flops align the input, a third gives the previous level.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= raw_in;
      stable <= meta;
      prev   <= stable;
    end
  end

  // Edges are seen only on the settled copy.
  always_comb begin
    rise_out = stable & ~prev;
    fall_out = ~stable & prev;
  end
endmodule

// ****************************************
// One up-counter with preload and modes
// ****************************************
module dtc_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire dtc_pkg::dtc_ctrl_t ctrl_in,
  input  wire logic             int_tick_in,
  input  wire logic             pin_rise_in,
  input  wire logic             pin_fall_in,
  input  wire logic             cmp_rise_in,
  input  wire logic             cmp_fall_in,
  input  wire logic             load_wr_in,
  input  wire logic [WIDTH-1:0] load_val_in,
  output var  logic [WIDTH-1:0] count_out,
  output var  logic             ovf_out,
  output var  logic             pw_done_out
);
  logic [WIDTH-1:0] preload;
  logic             pw_active;
  logic             pw_finished;
  logic             advance;
  logic             at_full;
  logic             start_edge;
  logic             return_edge;
  logic             pin_sel_edge;
  logic             cmp_sel_edge;

  // Choose the counting event for the current mode.
  always_comb begin
    pin_sel_edge = ctrl_in.edge_sel ? pin_fall_in : pin_rise_in;
    cmp_sel_edge = ctrl_in.edge_sel ? cmp_fall_in : cmp_rise_in;
    start_edge   = ctrl_in.edge_sel ? pin_rise_in : pin_fall_in;
    return_edge  = ctrl_in.edge_sel ? pin_fall_in : pin_rise_in;
    at_full      = &count_out;
    advance      = 1'b0;
    if (ctrl_in.run) begin
      unique case (ctrl_in.mode_sel)
        dtc_pkg::DTC_MODE_TIMER:     advance = int_tick_in;
        dtc_pkg::DTC_MODE_PULSE:     advance = pw_active & int_tick_in;
        dtc_pkg::DTC_MODE_EXT_EVENT: advance = pin_sel_edge;
        dtc_pkg::DTC_MODE_INT_EVENT: advance = cmp_sel_edge;
      endcase
    end
  end

  // Preload holds no reset value; software must write it first.
  always_ff @(posedge clk_in) begin
    if (load_wr_in) begin
      preload <= load_val_in;
    end
  end

  // Count register: direct load when stopped, reload on overflow.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count_out <= '0;
    end else if (load_wr_in && !ctrl_in.run) begin
      count_out <= load_val_in;
    end else if (advance && at_full) begin
      count_out <= load_wr_in ? load_val_in : preload;
    end else if (advance) begin
      count_out <= count_out + 1'b1;
    end
  end

  // Overflow request lasts a single cycle.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ovf_out <= 1'b0;
    end else begin
      ovf_out <= advance & at_full;
    end
  end

  // Pulse width capture: arm on start edge, finish on return edge.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pw_active   <= 1'b0;
      pw_finished <= 1'b0;
      pw_done_out <= 1'b0;
    end else if (!ctrl_in.run || ctrl_in.mode_sel != dtc_pkg::DTC_MODE_PULSE) begin
      pw_active   <= 1'b0;
      pw_finished <= 1'b0;
      pw_done_out <= 1'b0;
    end else begin
      pw_done_out <= pw_active & return_edge;
      if (pw_active && return_edge) begin
        pw_active   <= 1'b0;
        pw_finished <= 1'b1;
      end else if (!pw_active && !pw_finished && start_edge) begin
        pw_active <= 1'b1;
      end
    end
  end

  property p_overflow_reload;
    @(posedge clk_in) disable iff (!rstn_in)
    (advance && at_full && !load_wr_in) |=> (ovf_out && count_out == $past(preload));
  endproperty
  a_overflow_reload: assert property (p_overflow_reload) else $error("overflow did not reload");

  property p_ovf_cause;
    @(posedge clk_in) disable iff (!rstn_in)
    ovf_out |-> $past(advance) && $past(count_out) == {WIDTH{1'b1}};
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow pulse without full count");

  property p_stopped_load;
    @(posedge clk_in) disable iff (!rstn_in)
    (load_wr_in && !ctrl_in.run) |=> count_out == $past(load_val_in);
  endproperty
  a_stopped_load: assert property (p_stopped_load) else $error("stopped preload write missed count");

  property p_running_load;
    @(posedge clk_in) disable iff (!rstn_in)
    (load_wr_in && ctrl_in.run && !advance) |=> (count_out == $past(count_out) && preload == $past(load_val_in));
  endproperty
  a_running_load: assert property (p_running_load) else $error("running preload write touched count");

  property p_stopped_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    (!ctrl_in.run && !load_wr_in) [*2] |-> count_out == $past(count_out);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

  property p_event_step;
    @(posedge clk_in) disable iff (!rstn_in)
    (ctrl_in.run && ctrl_in.mode_sel == dtc_pkg::DTC_MODE_EXT_EVENT && !ctrl_in.edge_sel
      && pin_rise_in && !at_full && !load_wr_in) |=> count_out == $past(count_out) + WIDTH'(1);
  endproperty
  a_event_step: assert property (p_event_step) else $error("rising event not counted once");

  property p_event_no_prescale;
    @(posedge clk_in) disable iff (!rstn_in)
    (ctrl_in.mode_sel == dtc_pkg::DTC_MODE_EXT_EVENT && !pin_rise_in && !pin_fall_in && !load_wr_in)
      |=> count_out == $past(count_out);
  endproperty
  a_event_no_prescale: assert property (p_event_no_prescale) else $error("event counter moved without edge");

  property p_pw_done;
    @(posedge clk_in) disable iff (!rstn_in)
    (pw_active && return_edge && ctrl_in.run && ctrl_in.mode_sel == dtc_pkg::DTC_MODE_PULSE)
      |=> (pw_done_out && !pw_active);
  endproperty
  a_pw_done: assert property (p_pw_done) else $error("return edge did not end capture");
endmodule

// ****************************************
// Top: registers, clock sources, counters
// ****************************************
module dtc_timer_pair (
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       reg_wr_en_in,
  input  wire logic       reg_rd_en_in,
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       count8_event_pin_in,
  input  wire logic       count16_event_pin_in,
  input  wire logic       comparator1_out_in,
  input  wire logic       comparator2_out_in,
  input  wire logic       sub_clock_in,
  input  wire logic       count16_clk_option_in,
  output var  logic [7:0] reg_rdata_out,
  output var  logic       count8_irq_out,
  output var  logic       count16_irq_out,
  output var  logic       divider_clock_out
);
  dtc_pkg::dtc_ctrl_t                  count8_control;
  dtc_pkg::dtc_ctrl_t                  count16_control;
  logic                                divider_source_sel;
  logic [7:0]                          count16_low_buffer;
  logic [7:0]                          count16_low_latch;
  logic [`DTC_PRESCALE_WIDTH-1:0]      prescale_cnt;
  logic [7:0]                          prescale_mask;
  logic [1:0]                          sys_div4_cnt;
  logic                                tick8;
  logic                                tick16;
  logic [7:0]                          count8_value;
  logic [15:0]                         count16_value;
  logic                                ovf8;
  logic                                ovf16;
  logic                                pw_done8;
  logic                                pw_done16;
  logic                                pin8_rise;
  logic                                pin8_fall;
  logic                                pin16_rise;
  logic                                pin16_fall;
  logic                                cmp1_rise;
  logic                                cmp1_fall;
  logic                                cmp2_rise;
  logic                                cmp2_fall;
  logic                                sub_rise;
  logic                                wr8_value;
  logic                                wr16_high;

  // ****************************************
  // Input synchronisers
  // ****************************************
  dtc_sync_edge u_sync_pin8  (.clk_in(sys_clk_in), .rstn_in(rstn_in), .raw_in(count8_event_pin_in),
                              .rise_out(pin8_rise), .fall_out(pin8_fall));
  dtc_sync_edge u_sync_pin16 (.clk_in(sys_clk_in), .rstn_in(rstn_in), .raw_in(count16_event_pin_in),
                              .rise_out(pin16_rise), .fall_out(pin16_fall));
  dtc_sync_edge u_sync_cmp1  (.clk_in(sys_clk_in), .rstn_in(rstn_in), .raw_in(comparator1_out_in),
                              .rise_out(cmp1_rise), .fall_out(cmp1_fall));
  dtc_sync_edge u_sync_cmp2  (.clk_in(sys_clk_in), .rstn_in(rstn_in), .raw_in(comparator2_out_in),
                              .rise_out(cmp2_rise), .fall_out(cmp2_fall));
  dtc_sync_edge u_sync_sub   (.clk_in(sys_clk_in), .rstn_in(rstn_in), .raw_in(sub_clock_in),
                              .rise_out(sub_rise), .fall_out());

  // ****************************************
  // Internal clock enables
  // ****************************************

  // Free-running dividers for the prescaler and the divide-by-four tap.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      prescale_cnt <= '0;
      sys_div4_cnt <= '0;
    end else begin
      prescale_cnt <= prescale_cnt + 1'b1;
      sys_div4_cnt <= sys_div4_cnt + 1'b1;
    end
  end

  // Prescale ratio is two to the power of the select field.
  always_comb begin
    prescale_mask = (8'h01 << count8_control.prescale_sel) - 8'h01;
    tick8         = (prescale_cnt & prescale_mask[`DTC_PRESCALE_WIDTH-1:0])
                    == prescale_mask[`DTC_PRESCALE_WIDTH-1:0];
    tick16        = (count16_clk_option_in && count16_control.clock_sel) ? sub_rise
                    : (sys_div4_cnt == `DTC_SYS_DIV4_LAST);
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    wr8_value = reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT8_VALUE;
    wr16_high = reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT16_HIGH;
  end

  // Control registers; a software write beats the automatic run clear.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count8_control  <= `DTC_CTRL8_RESET;
      count16_control <= `DTC_CTRL16_RESET;
    end else begin
      if (reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT8_CONTROL) begin
        count8_control <= reg_wdata_in & `DTC_CTRL8_WRITE_MASK;
      end else if (pw_done8) begin
        count8_control.run <= 1'b0;
      end
      if (reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT16_CONTROL) begin
        count16_control <= reg_wdata_in & `DTC_CTRL16_WRITE_MASK;
      end else if (pw_done16) begin
        count16_control.run <= 1'b0;
      end
    end
  end

  // Divider source selection bit.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      divider_source_sel <= 1'b0;
    end else if (reg_wr_en_in && reg_addr_in == `DTC_IDX_MISC) begin
      divider_source_sel <= reg_wdata_in[`DTC_MISC_DIV_SEL_BIT];
    end
  end

  // Low byte writes land only in the holding buffer.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count16_low_buffer <= 8'h00;
    end else if (reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT16_LOW) begin
      count16_low_buffer <= reg_wdata_in;
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  dtc_counter #(.WIDTH(8)) u_count8 (
    .clk_in      (sys_clk_in),
    .rstn_in     (rstn_in),
    .ctrl_in     (count8_control),
    .int_tick_in (tick8),
    .pin_rise_in (pin8_rise),
    .pin_fall_in (pin8_fall),
    .cmp_rise_in (cmp1_rise),
    .cmp_fall_in (cmp1_fall),
    .load_wr_in  (wr8_value),
    .load_val_in (reg_wdata_in),
    .count_out   (count8_value),
    .ovf_out     (ovf8),
    .pw_done_out (pw_done8)
  );

  dtc_counter #(.WIDTH(16)) u_count16 (
    .clk_in      (sys_clk_in),
    .rstn_in     (rstn_in),
    .ctrl_in     (count16_control),
    .int_tick_in (tick16),
    .pin_rise_in (pin16_rise),
    .pin_fall_in (pin16_fall),
    .cmp_rise_in (cmp2_rise),
    .cmp_fall_in (cmp2_fall),
    .load_wr_in  (wr16_high),
    .load_val_in ({reg_wdata_in, count16_low_buffer}),
    .count_out   (count16_value),
    .ovf_out     (ovf16),
    .pw_done_out (pw_done16)
  );

  // ****************************************
  // Outputs and reads
  // ****************************************

  // Interrupt pulses and divider clock source follow overflow by one flop.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count8_irq_out    <= 1'b0;
      count16_irq_out   <= 1'b0;
      divider_clock_out <= 1'b0;
    end else begin
      count8_irq_out    <= ovf8;
      count16_irq_out   <= ovf16;
      divider_clock_out <= divider_source_sel ? ovf16 : ovf8;
    end
  end

  // Reading the high byte freezes the low byte for the next read.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count16_low_latch <= 8'h00;
    end else if (reg_rd_en_in && reg_addr_in == `DTC_IDX_COUNT16_HIGH) begin
      count16_low_latch <= count16_value[7:0];
    end
  end

  // Read data is registered; unmapped indices read zero.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_en_in) begin
      unique case (reg_addr_in)
        `DTC_IDX_COUNT8_VALUE:    reg_rdata_out <= count8_value;
        `DTC_IDX_COUNT16_LOW:     reg_rdata_out <= count16_low_latch;
        `DTC_IDX_COUNT16_HIGH:    reg_rdata_out <= count16_value[15:8];
        `DTC_IDX_COUNT8_CONTROL:  reg_rdata_out <= count8_control;
        `DTC_IDX_COUNT16_CONTROL: reg_rdata_out <= count16_control;
        `DTC_IDX_MISC:            reg_rdata_out <= {6'h00, divider_source_sel, 1'b0};
        default:                  reg_rdata_out <= 8'h00;
      endcase
    end
  end

  property p_low_latch;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (reg_rd_en_in && reg_addr_in == `DTC_IDX_COUNT16_HIGH) ##2
      (reg_rd_en_in && reg_addr_in == `DTC_IDX_COUNT16_LOW) |=> reg_rdata_out == $past(count16_low_latch);
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("low read not from latch");

  property p_read_count8;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (reg_rd_en_in && reg_addr_in == `DTC_IDX_COUNT8_VALUE) |=> reg_rdata_out == $past(count8_value);
  endproperty
  a_read_count8: assert property (p_read_count8) else $error("count read wrong value");

  property p_low_write_buffered;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT16_LOW && !count16_control.run)
      |=> (count16_low_buffer == $past(reg_wdata_in) && count16_value == $past(count16_value));
  endproperty
  a_low_write_buffered: assert property (p_low_write_buffered) else $error("low write changed count");

  property p_high_write;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (wr16_high && !count16_control.run) |=> count16_value == {$past(reg_wdata_in), $past(count16_low_buffer)};
  endproperty
  a_high_write: assert property (p_high_write) else $error("high write did not load both bytes");

  property p_run_autoclear;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (pw_done16 && !(reg_wr_en_in && reg_addr_in == `DTC_IDX_COUNT16_CONTROL)) |=> !count16_control.run;
  endproperty
  a_run_autoclear: assert property (p_run_autoclear) else $error("run bit not cleared after pulse");

  property p_irq_pulse;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(ovf8) |=> count8_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("overflow request not raised");
endmodule

`default_nettype wire

// [dtc_timer_pair_unused_note.sv]
// Holds no logic of its own; the whole timer pair lives in one design file.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [dtc_far_side.sv]
// Model of the event pins and comparator outputs that stand outside the timer pair.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Far-side line driver
// ****************************************
module dtc_far_side (
  input  wire logic       clk_in,
  output var  logic [3:0] line_out
);
  // Lines are 0 pin8, 1 comparator1, 2 pin16, 3 comparator2; all idle low after power-up.
  initial line_out = 4'h0;

  // Toggles one line k times, holding each level w cycles so the synchroniser sees it.
  task automatic toggles(input int idx, input int k, input int w);
    repeat (k) begin
      repeat (w) @(negedge clk_in);
      line_out[idx] = ~line_out[idx];
    end
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the timer pair.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, rstn, wr_en, rd_en, irq8, irq16, div_clk, lv, sub_clk, opt;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d, d1;
  logic [3:0] lines;
  int         n_errors, n_tests, c, cycles;

  dtc_timer_pair dtc_timer_pair_inst (.sys_clk_in(clk), .rstn_in(rstn), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .count8_event_pin_in(lines[0]),
    .count16_event_pin_in(lines[2]), .comparator1_out_in(lines[1]), .comparator2_out_in(lines[3]),
    .sub_clock_in(sub_clk), .count16_clk_option_in(opt), .reg_rdata_out(rdata),
    .count8_irq_out(irq8), .count16_irq_out(irq16), .divider_clock_out(div_clk));
  dtc_far_side dtc_far_side_inst (.clk_in(clk), .line_out(lines));

  // ****************************************
  // Shared tasks
  // ****************************************
  // Compares a seen value with the expected one and counts the result.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Writes are held for one rising edge; the next call waits a full cycle more.
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk); addr = a; wdata = v; wr_en = 1'b1;
    @(negedge clk); wr_en = 1'b0;
  endtask
  // Read data is taken one cycle after the strobe edge.
  task automatic rd_reg(input logic [2:0] a);
    @(negedge clk); addr = a; rd_en = 1'b1;
    @(negedge clk); rd_en = 1'b0; d = rdata;
  endtask
  // Waits for an overflow pulse and returns the cycles it took.
  task automatic wait_irq(input bit w);
    c = 0;
    do begin @(negedge clk); c++; end while ((w ? irq16 : irq8) !== 1'b1 && c < 3000);
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Control reset images and an unmapped index.
  task automatic s_reset;
    rd_reg(3'h3); check("count8_control", d, 8'h00);
    rd_reg(3'h4); check("count16_control", d, 8'h08);
    rd_reg(3'h6); check("unmapped", d, 8'h00);
    wr_reg(3'h5, 8'hFF); rd_reg(3'h5); check("misc", d, 8'h02);
    wr_reg(3'h5, 8'h00);
  endtask
  // Stopped load, overflow pulse, running preload that waits for the wrap.
  task automatic s_timer8;
    wr_reg(3'h0, 8'hFE); rd_reg(3'h0); check("count8 stopped load", d, 8'hFE);
    wr_reg(3'h3, 8'h90); wait_irq(1'b0); check("count8_irq", irq8, 1'b1);
    check("divider from count8", div_clk, 1'b1);
    @(negedge clk); check("count8_irq width", irq8, 1'b0);
    // Pulse mode with no pin edge keeps run set while the count stands still.
    wr_reg(3'h3, 8'hD0); rd_reg(3'h0); d1 = d;
    wr_reg(3'h0, 8'h40); rd_reg(3'h0); check("running load held", d, d1);
    wr_reg(3'h3, 8'h90); wait_irq(1'b0); rd_reg(3'h0); check("count8 after reload", d, 8'h42);
  endtask
  // Overflow period follows the prescale ratio in timer mode.
  task automatic s_prescale;
    for (int p = 0; p < 8; p++) begin
      wr_reg(3'h3, 8'h00); wr_reg(3'h0, 8'hFC); wr_reg(3'h3, 8'h90 | p[7:0]);
      wait_irq(1'b0); wait_irq(1'b0); check("count8 period", c, 4 << p);
    end
    wr_reg(3'h3, 8'h00);
  endtask
  // Buffered low write, latched low read, and the sys/4 period of the wide counter.
  task automatic s_count16;
    wr_reg(3'h1, 8'h34); rd_reg(3'h2); rd_reg(3'h1); check("low buffered", d, 8'h00);
    wr_reg(3'h2, 8'h12); rd_reg(3'h2); check("high load", d, 8'h12);
    rd_reg(3'h1); check("low moved", d, 8'h34);
    wr_reg(3'h4, 8'h98); repeat (20) @(negedge clk);
    rd_reg(3'h1); check("low latched", d, 8'h34);
    wr_reg(3'h4, 8'h08); wr_reg(3'h5, 8'h02); wr_reg(3'h1, 8'hF0); wr_reg(3'h2, 8'hFF);
    wr_reg(3'h4, 8'h98); wait_irq(1'b1); check("divider from count16", div_clk, 1'b1);
    wait_irq(1'b1); check("count16 period", c, 64);
    // With the option and the select bit set, each sub clock rise is one tick.
    opt = 1'b1; wr_reg(3'h4, 8'h08); wr_reg(3'h1, 8'hF0); wr_reg(3'h2, 8'hFF); wr_reg(3'h4, 8'hB8);
    fork
      repeat (100) begin repeat (3) @(negedge clk); sub_clk = ~sub_clk; end
      begin wait_irq(1'b1); wait_irq(1'b1); end
    join
    check("count16 sub clock period", c, 96);
    opt = 1'b0;
    wr_reg(3'h4, 8'h08);
  endtask
  // Pin and comparator events of both counters, both edge polarities, 8-bit prescaler set high.
  task automatic s_events;
    for (int u = 0; u < 2; u++) for (int s = 0; s < 2; s++) for (int e = 0; e < 2; e++) begin
      wr_reg(u ? 3'h4 : 3'h3, 8'h00);
      if (u) begin wr_reg(3'h1, 8'h00); wr_reg(3'h2, 8'h00); end
      else wr_reg(3'h0, 8'h00);
      wr_reg(u ? 3'h4 : 3'h3, {1'b0, s[0], 2'b01, e[0], u ? 3'h0 : 3'h7});
      lv = lines[2 * u + s];
      dtc_far_side_inst.toggles(2 * u + s, 7, 4); repeat (6) @(negedge clk);
      if (u) begin rd_reg(3'h2); rd_reg(3'h1); end
      else rd_reg(3'h0);
      check("event count", d, (e == 0) == lv ? 8'h03 : 8'h04);
    end
  endtask
  // One pulse per counter is measured, run clears itself, later pulses are ignored.
  task automatic s_pulse;
    for (int u = 0; u < 2; u++) begin
      wr_reg(u ? 3'h4 : 3'h3, 8'h00); wr_reg(u ? 3'h2 : 3'h0, 8'h00);
      if (lines[2 * u] !== (u == 0)) dtc_far_side_inst.toggles(2 * u, 1, 1);
      repeat (6) @(negedge clk); wr_reg(u ? 3'h4 : 3'h3, u ? 8'hD8 : 8'hD0);
      dtc_far_side_inst.toggles(2 * u, 2, 20); repeat (8) @(negedge clk);
      rd_reg(u ? 3'h4 : 3'h3); check("run cleared", d, u ? 8'hC8 : 8'hC0);
      if (u) begin rd_reg(3'h2); rd_reg(3'h1); end
      else rd_reg(3'h0);
      d1 = d; check("pulse counted", d1, u ? 8'h05 : 8'h14);
      dtc_far_side_inst.toggles(2 * u, 2, 10); repeat (8) @(negedge clk);
      if (u) begin rd_reg(3'h2); rd_reg(3'h1); end
      else rd_reg(3'h0);
      check("count held", d, d1);
    end
  endtask

  // ****************************************
  // Clock, reset, timeout and sequence
  // ****************************************
  // Free-running system clock of 20 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang is counted as a mismatch and closes the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Reset for two cycles, then every scenario in turn.
  initial begin
    rstn = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 3'h0; wdata = 8'h00;
    sub_clk = 1'b0; opt = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    s_reset(); s_timer8(); s_prescale(); s_count16(); s_events(); s_pulse();
    print_verdict();
  end
endmodule
`default_nettype wire
